/* src/emc_pkg.sv */
/*
 * Constants, register map and state encoding for the external memory
 * configuration block. Assumes a byte-wide special-function register bus.
 */
//
// Operation
// - With the port enable bit clear the interface never drives the pins; set, it uses the high ports.
// - The bus-style bit picks multiplexed (clear) or separate (set) address and data pins.
// - Mode 00 sends every external move on-chip, with addresses aliased into the on-chip space.
// - Mode 01 splits at 4k, and short off-chip accesses take the high byte from the port latch.
// - Mode 10 splits at 4k, and short off-chip accesses use the page select register as high byte.
// - Mode 11 sends every external move off-chip and hides the on-chip memory.
// - The strobe width field gives 1, 2, 3 or 4 cycles high and low, and acts only when multiplexed.
// - In multiplexed mode data and the low address byte share the same eight pins.
// - In multiplexed mode the interface drives the address latch strobe.
// - In the first multiplexed phase the strobe is high and the low address sits on the shared pins.
// - After the strobe falls the shared pins carry data by the time read or write is asserted.
// - In separate mode address and data use their own pins and no latch strobe is used.
// - Pins are claimed only while an off-chip access runs and are then handed back.
// - A short access forms its address from the page select register and the index byte; modes 01 and 11 drive the port latch as high byte.
package emc_pkg;
    localparam logic [7:0] CFG_ADDR = 8'hA3;
    localparam logic [7:0] PAGE_ADDR = 8'hA2;
    localparam logic [7:0] CFG_RESET = 8'h03;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam int PORT_EN_BIT = 5;
    localparam int BUS_STYLE_BIT = 4;
    localparam int MODE_LSB = 2;
    localparam int WIDTH_LSB = 0;
    localparam logic [1:0] MODE_INTERNAL = 2'h0;
    localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
    localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
    localparam logic [1:0] MODE_EXTERNAL = 2'h3;
    localparam logic [15:0] ONCHIP_LIMIT = 16'h1000;
    localparam logic [2:0] ALE_MAX_CYC = 3'h4;
    localparam int STROBE_CYC = 1;
    localparam logic [2:0] HOLD_CYC = 3'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_ALE_HI = 3'b010,
        ST_ALE_LO = 3'b011,
        ST_STROBE = 3'b100,
        ST_HOLD = 3'b101
    } emc_state_t;
endpackage

/* src/emc_ctrl.sv */
/*
 * External data memory interface: configuration and page registers on the
 * register bus, address routing for external moves, and the pin sequencer.
 * Assumes the core issues one access at a time and waits for off-chip done.
 */
`timescale 1ns/100ps
`default_nettype none
module emc_ctrl import emc_pkg::*; #(
    parameter int STROBE_CYCLES = STROBE_CYC
) (
    input wire logic sys_clk, // Core clock
    input wire logic nrst, // Async reset, low
    input wire logic [7:0] sfr_addr, // Register address
    input wire logic sfr_wr, // Register write strobe
    input wire logic sfr_rd, // Register read strobe
    input wire logic [7:0] sfr_wdata, // Register write data
    output logic [7:0] sfr_rdata, // Register read data, next cycle
    input wire logic acc_req, // External move request pulse
    input wire logic acc_wr, // Request is a write
    input wire logic acc_short, // Indexed 8-bit form
    input wire logic [15:0] acc_ptr, // 16-bit pointer
    input wire logic [7:0] acc_idx, // Index byte for short form
    input wire logic [7:0] acc_wdata, // Write data
    input wire logic [7:0] hi_port_latch, // High address port latch
    output logic acc_busy, // Off-chip access running
    output logic acc_done, // Off-chip access done pulse
    output logic [7:0] acc_rdata, // Off-chip read data
    output logic onchip_req, // On-chip access pulse
    output logic [11:0] onchip_addr, // Aliased on-chip address
    output logic [7:0] ad_o, // Shared low address/data pins
    output logic ad_oe_n, // Shared pins enable, low drives
    input wire logic [7:0] ad_i, // Shared pins level
    output logic [7:0] alo_o, // Separate low address pins
    output logic alo_oe_n, // Low address enable, low drives
    output logic [7:0] ahi_o, // High address pins
    output logic ahi_oe_n, // High address enable, low drives
    output logic ale_o, // Address latch strobe
    output logic ale_oe_n, // Latch strobe enable, low drives
    output logic rd_n_o, // Read strobe, low active
    output logic wr_n_o, // Write strobe, low active
    output logic strb_oe_n // Read/write strobe enable, low drives
);
    typedef struct packed {
        // Register file
        logic [5:0] cfg;
        logic [7:0] page;
        logic [7:0] rdata;
        // Sequencer and the request it latched
        emc_state_t st;
        logic [2:0] cnt;
        logic claim;
        logic wr;
        logic [7:0] wdata;
        logic [2:0] ale_n;
        // Answers to the core
        logic busy;
        logic done;
        logic [7:0] acc_rd;
        logic onreq;
        logic [11:0] onaddr;
        // Pin drivers, each group with its own enable
        logic [7:0] ad;
        logic ad_oe_n;
        logic [7:0] alo;
        logic alo_oe_n;
        logic [7:0] ahi;
        logic ahi_oe_n;
        logic ale;
        logic ale_oe_n;
        logic rd_n;
        logic wr_n;
        logic strb_oe_n;
        // Two-flop synchroniser on the shared pins
        logic [7:0] sync1;
        logic [7:0] sync2;
    } emc_regs_t;

    localparam logic [2:0] STROBE_LAST = 3'(STROBE_CYCLES - 1);

    // The phase counter is three bits wide, so no phase may exceed eight cycles
    if (STROBE_CYCLES < 1 || STROBE_CYCLES > 8) begin : g_bad_strobe
        $error("STROBE_CYCLES must lie in 1..8");
    end

    // Read data needs two hold edges to clear the pin synchroniser
    if (HOLD_CYC < 3'h2) begin : g_bad_hold
        $error("HOLD_CYC must be at least 2");
    end

    // Code 11 must stay the widest strobe setting
    if (ALE_MAX_CYC < 3'h4) begin : g_bad_ale
        $error("ALE_MAX_CYC must be at least 4");
    end

    // Width code 11 is the longest setting
    function automatic logic [2:0] ale_cycles(input logic [1:0] code);
        ale_cycles = (code == 2'h3) ? ALE_MAX_CYC : {1'b0, code} + 3'h1;
    endfunction

    // Register decodes, shared by the write and the read path
    function automatic logic is_cfg(input logic [7:0] addr);
        is_cfg = (addr == CFG_ADDR);
    endfunction

    function automatic logic is_page(input logic [7:0] addr);
        is_page = (addr == PAGE_ADDR);
    endfunction

    // Pins are enabled only when the port enable bit is set at the start
    function automatic logic claim_n(input logic [5:0] cfg);
        claim_n = !cfg[PORT_EN_BIT];
    endfunction

    // Mode 00 never leaves the chip and 11 always does; the split modes cut at 4k
    function automatic logic goes_offchip(input logic [1:0] md, input logic [15:0] addr);
        unique case (md)
            MODE_INTERNAL: goes_offchip = 1'b0;
            MODE_EXTERNAL: goes_offchip = 1'b1;
            default: goes_offchip = (addr >= ONCHIP_LIMIT);
        endcase
    endfunction

    // Hands every pin group back to the port latches in one step
    function automatic emc_regs_t drop_pins(input emc_regs_t r);
        drop_pins = r;
        drop_pins.ad_oe_n = 1'b1;
        drop_pins.alo_oe_n = 1'b1;
        drop_pins.ahi_oe_n = 1'b1;
        drop_pins.ale_oe_n = 1'b1;
        drop_pins.strb_oe_n = 1'b1;
        drop_pins.ale = 1'b0;
        drop_pins.rd_n = 1'b1;
        drop_pins.wr_n = 1'b1;
    endfunction

    // Reset image: interface off the pins, every strobe idle
    localparam emc_regs_t RST = '{
        cfg: CFG_RESET[5:0], page: PAGE_RESET, st: ST_IDLE,
        ad_oe_n: 1'b1, alo_oe_n: 1'b1, ahi_oe_n: 1'b1,
        ale_oe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, strb_oe_n: 1'b1,
        default: '0
    };

    emc_regs_t s_q;
    emc_regs_t s_d;

    // Routing is decided from the request and the configuration in one cycle
    logic [1:0] mode;
    logic [15:0] ea;
    logic offchip;
    logic hi_from_port;

    always_comb begin
        mode = s_q.cfg[MODE_LSB +: 2];
        ea = acc_short ? {s_q.page, acc_idx} : acc_ptr;
        offchip = goes_offchip(mode, ea);
        // No-bank and external-only short accesses reuse the port latch byte
        hi_from_port = acc_short && (mode != MODE_SPLIT_BANK);
    end

    // One next-state image for the whole block: registers, sequencer and pins
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.onreq = 1'b0;
        s_d.sync1 = ad_i;
        s_d.sync2 = s_q.sync1;
        // Bits 7:6 are not stored, so writes to them are lost and they read zero
        if (sfr_wr && is_cfg(sfr_addr)) begin
            s_d.cfg = sfr_wdata[5:0];
        end
        if (sfr_wr && is_page(sfr_addr)) begin
            s_d.page = sfr_wdata;
        end
        // Read data is registered and stands until the next read strobe
        if (sfr_rd) begin
            if (is_cfg(sfr_addr)) begin
                s_d.rdata = {2'b00, s_q.cfg};
            end else if (is_page(sfr_addr)) begin
                s_d.rdata = s_q.page;
            end else begin
                // Unmapped addresses read zero
                s_d.rdata = 8'h00;
            end
        end
        unique case (s_q.st)
            ST_IDLE: begin
                if (acc_req && !offchip) begin
                    // On-chip accesses only pulse; the pins are never touched
                    s_d.onreq = 1'b1;
                    s_d.onaddr = ea[11:0];
                end else if (acc_req) begin
                    // Configuration is sampled here; later writes wait for the next access
                    s_d.busy = 1'b1;
                    s_d.wr = acc_wr;
                    s_d.wdata = acc_wdata;
                    s_d.claim = s_q.cfg[PORT_EN_BIT];
                    s_d.ale_n = ale_cycles(s_q.cfg[WIDTH_LSB +: 2]);
                    s_d.ahi = hi_from_port ? hi_port_latch : ea[15:8];
                    s_d.ahi_oe_n = claim_n(s_q.cfg);
                    s_d.strb_oe_n = claim_n(s_q.cfg);
                    if (!s_q.cfg[BUS_STYLE_BIT]) begin
                        // Address phase on the shared pins with the latch open
                        s_d.ad = ea[7:0];
                        s_d.ad_oe_n = claim_n(s_q.cfg);
                        s_d.ale = 1'b1;
                        s_d.ale_oe_n = claim_n(s_q.cfg);
                        s_d.cnt = ale_cycles(s_q.cfg[WIDTH_LSB +: 2]) - 3'h1;
                        s_d.st = ST_ALE_HI;
                    end else begin
                        s_d.alo = ea[7:0];
                        s_d.alo_oe_n = claim_n(s_q.cfg);
                        s_d.cnt = 3'h0;
                        s_d.st = ST_SETUP;
                    end
                end
            end

            ST_ALE_HI: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.ale = 1'b0; // latch freezes on this fall
                    s_d.cnt = s_q.ale_n - 3'h1;
                    s_d.st = ST_ALE_LO;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end

            ST_ALE_LO, ST_SETUP: begin
                if (s_q.cnt == 3'h0) begin
                    // Data goes out with the strobe edge so a write never shows address
                    s_d.ad = s_q.wdata;
                    s_d.ad_oe_n = !(s_q.claim && s_q.wr);
                    s_d.rd_n = s_q.wr;
                    s_d.wr_n = !s_q.wr;
                    s_d.cnt = STROBE_LAST;
                    s_d.st = ST_STROBE;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end

            ST_STROBE: begin
                if (s_q.cnt == 3'h0) begin
                    // Both strobes rise before the hold phase, whichever was low
                    s_d.rd_n = 1'b1;
                    s_d.wr_n = 1'b1;
                    s_d.cnt = HOLD_CYC - 3'h1;
                    s_d.st = ST_HOLD;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end

            ST_HOLD: begin
                if (s_q.cnt == 3'h0) begin
                    // Hold covers the synchroniser delay on the read path
                    s_d.acc_rd = s_q.wr ? 8'h00 : s_q.sync2;
                    s_d.done = 1'b1;
                    s_d.busy = 1'b0;
                    // Pins go back to the port latches in the cycle the access ends
                    s_d = drop_pins(s_d);
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end

            default: begin
                s_d = RST;
            end
        endcase
    end

    // Reset loads the constant image only; nothing is computed under nrst
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Core side
    assign sfr_rdata = s_q.rdata;
    assign acc_busy = s_q.busy;
    assign acc_done = s_q.done;
    assign acc_rdata = s_q.acc_rd;
    assign onchip_req = s_q.onreq;
    assign onchip_addr = s_q.onaddr;

    // Address and data pins: each pin and enable is a flop bit, so nothing glitches
    assign ad_o = s_q.ad;
    assign ad_oe_n = s_q.ad_oe_n;
    assign alo_o = s_q.alo;
    assign alo_oe_n = s_q.alo_oe_n;
    assign ahi_o = s_q.ahi;
    assign ahi_oe_n = s_q.ahi_oe_n;

    // Read and write strobes idle high, the latch strobe idles low; all are enabled only while the pins are claimed
    assign ale_o = s_q.ale;
    assign ale_oe_n = s_q.ale_oe_n;
    assign rd_n_o = s_q.rd_n;
    assign wr_n_o = s_q.wr_n;
    assign strb_oe_n = s_q.strb_oe_n;
endmodule // emc_ctrl
`default_nettype wire

/* sim/emc_ctrl_asserts.sv */
/* Port checker for emc_ctrl.
   Bound to every emc_ctrl instance; sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module emc_ctrl_asserts (
    input wire logic sys_clk, // Core clock
    input wire logic nrst, // Async reset, low
    input wire logic acc_req, // Request pulse
    input wire logic acc_busy, // Off-chip running
    input wire logic acc_done, // Done pulse
    input wire logic onchip_req, // On-chip pulse
    input wire logic ad_oe_n, // Shared pins enable
    input wire logic alo_oe_n, // Low address enable
    input wire logic ale_o, // Latch strobe
    input wire logic ale_oe_n, // Strobe enable
    input wire logic rd_n_o, // Read strobe
    input wire logic wr_n_o, // Write strobe
    input wire logic strb_oe_n // Read/write enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_start;
        acc_req && !acc_busy;
    endsequence
    sequence s_strobe;
        !rd_n_o || !wr_n_o;
    endsequence
    a_start_answered: assert property (s_start |=> acc_busy || onchip_req)
        else $error("request not answered");
    a_onchip_idle: assert property (onchip_req |-> !acc_busy)
        else $error("on-chip pulse during off-chip access");
    a_pins_released: assert property (!acc_busy |-> ad_oe_n && alo_oe_n && ale_oe_n && strb_oe_n)
        else $error("pins held outside access");
    a_done_bounded: assert property ($rose(acc_busy) |-> ##[1:16] acc_done)
        else $error("access never finished");
    a_done_single: assert property (acc_done |-> !acc_busy ##1 !acc_done)
        else $error("done not a single pulse");
    a_strobe_busy: assert property (ale_o |-> acc_busy)
        else $error("latch strobe outside access");
    a_strobe_follows: assert property ($fell(ale_o) |-> ##[1:8] s_strobe)
        else $error("no read or write after strobe fall");
    a_strobes_apart: assert property (!(!rd_n_o && !wr_n_o))
        else $error("read and write both low");
    a_no_strobe_ale: assert property (ale_o |-> rd_n_o && wr_n_o)
        else $error("read or write during address phase");
endmodule // emc_ctrl_asserts
bind emc_ctrl emc_ctrl_asserts u_chk (.sys_clk, .nrst, .acc_req, .acc_busy, .acc_done,
    .onchip_req, .ad_oe_n, .alo_oe_n, .ale_o, .ale_oe_n, .rd_n_o, .wr_n_o, .strb_oe_n);
`default_nettype wire

/* sim/emc_far_mem.sv */
/* Far side: transparent address latch and a 256-byte memory.
   Assumes emc_ctrl split pins; a released shared bus shows no stale value. */
`timescale 1ns/100ps
`default_nettype none
module emc_far_mem (
    input wire logic sys_clk, // Core clock
    input wire logic [7:0] ad_o, // Shared pins out
    input wire logic ad_oe_n, // Shared pins enable
    input wire logic [7:0] alo_o, // Separate low address
    input wire logic alo_oe_n, // Low address enable
    input wire logic ale_o, // Latch strobe
    input wire logic ale_oe_n, // Strobe enable
    input wire logic rd_n_o, // Read strobe
    input wire logic wr_n_o, // Write strobe
    input wire logic strb_oe_n, // Strobe enable
    output logic [7:0] ad_i // Shared pin level
);
    logic [7:0] lat_q;
    logic [7:0] last_q;
    logic [7:0] mem [256];
    logic [7:0] addr;
    always_latch if (ale_o && !ale_oe_n) lat_q <= ad_o;
    assign addr = alo_oe_n ? lat_q : alo_o;
    always_ff @(posedge sys_clk) begin
        if (!wr_n_o && !strb_oe_n && !ad_oe_n) mem[addr] <= ad_o;
        last_q <= ad_i;
    end
    // Undriven bus flips so a stale byte can never pass as read data
    assign ad_i = !ad_oe_n ? ad_o : (!rd_n_o && !strb_oe_n) ? mem[addr] : ~last_q;
endmodule // emc_far_mem
`default_nettype wire

/* sim/testbench.sv */
/* Self-checking bench for emc_ctrl with the far-side memory model.
   Assumes emc_pkg constants and the hand-over timing. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import emc_pkg::*;
    logic sys_clk, nrst, sfr_wr, sfr_rd, acc_req, acc_wr, acc_short, acc_busy, acc_done;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc_idx, acc_wdata, hi_port_latch, acc_rdata;
    logic [7:0] ad_o, ad_i, alo_o, ahi_o, a0, ah, rd;
    logic [15:0] acc_ptr;
    logic [11:0] onchip_addr;
    logic onchip_req, ad_oe_n, alo_oe_n, ahi_oe_n, ale_o, ale_oe_n, rd_n_o, wr_n_o, strb_oe_n;
    logic oe, on;
    int err_count, samples_checked, n, al;
    emc_ctrl u_dut (.sys_clk, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .acc_req, .acc_wr, .acc_short, .acc_ptr, .acc_idx, .acc_wdata, .hi_port_latch,
        .acc_busy, .acc_done, .acc_rdata, .onchip_req, .onchip_addr, .ad_o, .ad_oe_n, .ad_i,
        .alo_o, .alo_oe_n, .ahi_o, .ahi_oe_n, .ale_o, .ale_oe_n, .rd_n_o, .wr_n_o, .strb_oe_n);
    emc_far_mem u_mem (.sys_clk, .ad_o, .ad_oe_n, .alo_o, .alo_oe_n, .ale_o, .ale_oe_n,
        .rd_n_o, .wr_n_o, .strb_oe_n, .ad_i);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        {sfr_addr, sfr_rd} <= {a, 1'b1};
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        @(posedge sys_clk);
        #1 chk(sfr_rdata, exp);
    endtask
    // One access from request to done or on-chip pulse; records what the pins showed
    task automatic acc(input logic w, input logic s, input logic [15:0] p, input logic [7:0] d);
        {n, al, oe} = {32'h0, 32'h0, 1'b1};
        @(posedge sys_clk);
        {acc_req, acc_wr, acc_short, acc_ptr, acc_idx, acc_wdata} <= {1'b1, w, s, p, p[7:0], d};
        @(posedge sys_clk);
        acc_req <= 1'b0;
        // First look is just after the edge that took the request
        forever begin
            #1 n++;
            if (n == 1) ah = ahi_o;
            if (ale_o && al == 0) a0 = ad_o;
            if (ale_o) al++;
            if (!ad_oe_n || !alo_oe_n || !ahi_oe_n || !ale_oe_n || !strb_oe_n) oe = 1'b0;
            if (acc_done || onchip_req || n >= 40) break;
            @(posedge sys_clk);
        end
        if (n >= 40) err_count++;
        {on, rd} = {onchip_req, acc_rdata};
    endtask
    task automatic t_regs;
        reg_rd(CFG_ADDR, 8'h03);
        reg_rd(PAGE_ADDR, 8'h00);
        reg_wr(CFG_ADDR, 8'hFF);
        reg_rd(CFG_ADDR, 8'h3F);
        reg_wr(8'h77, 8'hFF);
        reg_rd(8'h77, 8'h00);
    endtask
    task automatic t_routing;
        for (int m = 0; m < 4; m++) begin
            reg_wr(CFG_ADDR, 8'h20 | 8'(m << 2));
            acc(1'b0, 1'b0, 16'h0800, 8'h00);
            chk(on, m != 3);
            acc(1'b0, 1'b0, 16'h2345, 8'h00);
            chk(on, m == 0);
            if (m == 0) chk(onchip_addr, 12'h345);
        end
    endtask
    task automatic t_mux;
        for (int c = 0; c < 4; c++) begin
            reg_wr(CFG_ADDR, 8'h2C | 8'(c));
            acc(1'b1, 1'b0, 16'h12A0 + 16'(c), 8'h5A ^ 8'(c));
            chk(16'(n), 16'(2 * c + 6));
            chk(16'(al), 16'(c + 1));
            chk({ah, a0}, 16'h12A0 + 16'(c));
            chk(oe, 1'b0);
            acc(1'b0, 1'b0, 16'h12A0 + 16'(c), 8'h00);
            chk(rd, 8'h5A ^ 8'(c));
        end
    endtask
    task automatic t_nonmux;
        reg_wr(CFG_ADDR, 8'h3F);
        acc(1'b1, 1'b0, 16'h3377, 8'hC3);
        chk(16'(n), 16'h0005);
        chk(16'(al), 16'h0000);
        acc(1'b0, 1'b0, 16'h3377, 8'h00);
        chk(rd, 8'hC3);
    endtask
    task automatic t_short;
        reg_wr(PAGE_ADDR, 8'h56);
        reg_wr(CFG_ADDR, 8'h28);
        acc(1'b0, 1'b1, 16'h0021, 8'h00);
        chk({ah, a0}, 16'h5621);
        reg_wr(CFG_ADDR, 8'h24);
        hi_port_latch <= 8'hE7;
        acc(1'b0, 1'b1, 16'h0021, 8'h00);
        chk(ah, 8'hE7);
        reg_wr(PAGE_ADDR, 8'h0F);
        acc(1'b0, 1'b1, 16'h0021, 8'h00);
        chk(on, 1'b1);
    endtask
    task automatic t_port_off;
        reg_wr(CFG_ADDR, 8'h0C);
        acc(1'b1, 1'b0, 16'h40A0, 8'h99);
        chk(oe, 1'b1);
        reg_wr(CFG_ADDR, 8'h2C);
        acc(1'b0, 1'b0, 16'h40A0, 8'h00);
        chk(rd, 8'h5A);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {nrst, sfr_wr, sfr_rd, acc_req, acc_wr, acc_short} = 6'h00;
        {sfr_addr, sfr_wdata, acc_idx, acc_wdata, hi_port_latch, acc_ptr} = 56'h0;
        {err_count, samples_checked} = {32'h0, 32'h0};
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs;
        t_routing;
        t_mux;
        t_nonmux;
        t_short;
        t_port_off;
        tally_and_finish;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #50000;
        err_count++;
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
